// File: dpfc_panel.sv
// Purpose: front panel spindle, fault, ready, lockout and port control
// Assumes: panel and drive inputs synchronous to aclk, buttons debounced
// Notes: registers over AXI4-Lite; one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module dpfc_panel #(
	parameter int BLINK_CYCLES = dpfc_pkg::BLINK_CYCLES,
	parameter int LOG_DEPTH = dpfc_pkg::LOG_DEPTH
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// panel buttons, level while latched in
	input wire logic spindle_button_in,
	input wire logic lockout_button_lamp_in,
	input wire logic port_a_button_in,
	input wire logic port_b_button_in,
	input wire logic error_button,
	// drive mechanics
	input wire logic spindle_rotating,
	input wire logic spindle_at_speed,
	input wire logic seek_active,
	input wire logic writes_pending,
	input wire logic fault_detect,
	input wire logic [4:0] fault_code_in,
	input wire logic fault_self_corrected,
	// selection
	input wire logic [3:0] unit_code,
	input wire logic [3:0] select_addr,
	input wire logic dual_port_fitted,
	// drive controls
	output logic spindle_motor_q,
	output logic heads_retract_q,
	output logic fault_clear_q,
	output logic write_enable_q,
	output logic online_q,
	output logic selected_q,
	output logic port_a_enable_q,
	output logic port_b_enable_q,
	// lamps {spindle, error, ready, lockout, port_a, port_b}
	output logic [5:0] lamps_q
);
	localparam int LW = $clog2(LOG_DEPTH);
	dpfc_pkg::dpfc_state_type state_q, state_d;
	logic [2:0] ctrl_q;
	logic spin_req_q, start_ok_q, fault_q, disp_q, err_btn_q;
	logic [4:0] code_q;
	logic [4:0] log_mem [0:LOG_DEPTH-1];
	logic [LW-1:0] log_wr_q, log_sel_q;
	logic [LW:0] log_cnt_q;
	logic aw_got_q, w_got_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic ready_cond_q;
	logic [5:0] normal_lamps;

	// panel decode
	wire press = error_button & ~err_btn_q;
	wire first_press = press & ~disp_q;
	wire second_press = press & disp_q;
	wire host_spin = spin_req_q & spindle_button_in;
	wire start = spindle_button_in & (start_ok_q | host_spin) & ~fault_q;
	wire stop = ~spindle_button_in;
	wire ready_cond = (state_q == dpfc_pkg::ST_READY) & spindle_button_in &
		spindle_rotating & ~seek_active & ~fault_q;
	wire drain = state_q == dpfc_pkg::ST_DRAIN;
	wire wr_ok = (ready_cond | drain) & ~lockout_button_lamp_in;
	wire dual = dual_port_fitted & port_a_button_in & port_b_button_in;
	wire port_a_d = ~disp_q & (dual ? ~ctrl_q[dpfc_pkg::CTRL_PORT_B_BIT] :
		(port_a_button_in & ~port_b_button_in));
	wire port_b_d = ~disp_q & (dual ? ctrl_q[dpfc_pkg::CTRL_PORT_B_BIT] :
		(port_b_button_in & ~port_a_button_in));
	wire online_d = ~disp_q & ~ctrl_q[dpfc_pkg::CTRL_DISABLE_BIT];
	wire selected_d = online_d & (select_addr == unit_code);

	// spindle sequencer
	always_comb begin
		state_d = state_q;
		case (state_q)
			dpfc_pkg::ST_STOPPED:
				if (start)
					state_d = dpfc_pkg::ST_SPINUP;
			dpfc_pkg::ST_SPINUP:
				if (fault_detect | fault_q | stop)
					state_d = dpfc_pkg::ST_SPINDOWN;
				else if (spindle_at_speed)
					state_d = dpfc_pkg::ST_READY;
			dpfc_pkg::ST_READY:
				if (stop)
					state_d = writes_pending ? dpfc_pkg::ST_DRAIN :
						dpfc_pkg::ST_SPINDOWN;
			dpfc_pkg::ST_DRAIN:
				if (!writes_pending)
					state_d = dpfc_pkg::ST_SPINDOWN;
			dpfc_pkg::ST_SPINDOWN:
				if (!spindle_rotating)
					state_d = dpfc_pkg::ST_STOPPED;
			default:
				state_d = dpfc_pkg::ST_STOPPED;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= dpfc_pkg::ST_STOPPED;
			spindle_motor_q <= 1'b0;
			heads_retract_q <= 1'b1;
		end else begin
			state_q <= state_d;
			spindle_motor_q <= (state_d == dpfc_pkg::ST_SPINUP) |
				(state_d == dpfc_pkg::ST_READY) |
				(state_d == dpfc_pkg::ST_DRAIN);
			heads_retract_q <= (state_d == dpfc_pkg::ST_SPINDOWN) |
				(state_d == dpfc_pkg::ST_STOPPED);
		end
	end

	// power-up with button in: wait for a release or a host spin request before starting
	always_ff @(posedge aclk) begin
		if (!aresetn)
			start_ok_q <= 1'b0;
		else if (stop)
			start_ok_q <= 1'b1;
		else if (state_q == dpfc_pkg::ST_SPINUP)
			start_ok_q <= 1'b0;
	end

	// fault latch: a new detect wins over any clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_q <= 1'b0;
			code_q <= 5'h00;
			disp_q <= 1'b0;
			err_btn_q <= 1'b0;
			fault_clear_q <= 1'b0;
		end else begin
			err_btn_q <= error_button;
			fault_clear_q <= second_press;
			if (fault_detect)
				fault_q <= 1'b1;
			else if (fault_self_corrected | second_press)
				fault_q <= 1'b0;
			if (fault_detect & ~fault_q & ~disp_q)
				code_q <= fault_code_in;
			if (first_press)
				disp_q <= 1'b1;
			else if (second_press)
				disp_q <= 1'b0;
		end
	end

	// error log, circular; oldest entry overwritten past the depth
	always_ff @(posedge aclk) begin
		if (second_press)
			log_mem[log_wr_q] <= code_q;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			log_wr_q <= '0;
			log_cnt_q <= '0;
		end else if (second_press) begin
			log_wr_q <= log_wr_q + 1'b1;
			if (log_cnt_q != (LW+1)'(LOG_DEPTH))
				log_cnt_q <= log_cnt_q + 1'b1;
		end
	end

	// drive outputs and normal lamps
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ready_cond_q <= 1'b0;
			write_enable_q <= 1'b0;
			online_q <= 1'b0;
			selected_q <= 1'b0;
			port_a_enable_q <= 1'b0;
			port_b_enable_q <= 1'b0;
		end else begin
			ready_cond_q <= ready_cond;
			write_enable_q <= wr_ok;
			online_q <= online_d;
			selected_q <= selected_d;
			port_a_enable_q <= port_a_d;
			port_b_enable_q <= port_b_d;
		end
	end
	assign normal_lamps = {spindle_rotating, fault_q, ready_cond,
		lockout_button_lamp_in, port_a_d, port_b_d};

	dpfc_lamp_mux #(
		.BLINK_CYCLES(BLINK_CYCLES)
	) u_lamps (
		.aclk(aclk),
		.aresetn(aresetn),
		.display_on(disp_q),
		.fault_code(code_q),
		.normal_lamps(normal_lamps),
		.lamps_q(lamps_q)
	);

	// axi4-lite write side: address and data taken in either order
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_got_q | aw_hs;
	wire w_have = w_got_q | w_hs;
	wire [7:0] wa = aw_got_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wd = w_got_q ? w_data_q : s_axi_wdata;
	wire [3:0] ws = w_got_q ? w_strb_q : s_axi_wstrb;
	wire do_wr = aw_have & w_have & ~s_axi_bvalid;
	wire wr_ctrl = do_wr & (wa == dpfc_pkg::CTRL_OFFSET) & ws[0];
	wire wr_sel = do_wr & (wa == dpfc_pkg::LOG_SEL_OFFSET) & ws[0];
	wire wr_hit = (wa == dpfc_pkg::CTRL_OFFSET) |
		(wa == dpfc_pkg::LOG_SEL_OFFSET);
	wire b_done = s_axi_bvalid & s_axi_bready;
	wire aw_got_d = aw_have & ~do_wr;
	wire w_got_d = w_have & ~do_wr;
	wire bvalid_d = do_wr | (s_axi_bvalid & ~s_axi_bready);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= dpfc_pkg::RESP_OKAY;
		end else begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			if (aw_hs)
				aw_addr_q <= s_axi_awaddr;
			if (w_hs) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			s_axi_awready <= ~aw_got_d & ~bvalid_d & ~aw_hs;
			s_axi_wready <= ~w_got_d & ~bvalid_d & ~w_hs;
			s_axi_bvalid <= bvalid_d;
			if (do_wr)
				s_axi_bresp <= wr_hit ? dpfc_pkg::RESP_OKAY :
					dpfc_pkg::RESP_SLVERR;
		end
	end

	// control register; spin request bit clears once it starts a spin-up
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= dpfc_pkg::CTRL_RESET;
			spin_req_q <= 1'b0;
			log_sel_q <= '0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= wd[2:0];
			if (wr_ctrl & wd[dpfc_pkg::CTRL_SPIN_REQ_BIT])
				spin_req_q <= 1'b1;
			else if (state_q != dpfc_pkg::ST_STOPPED)
				spin_req_q <= 1'b0;
			if (wr_sel)
				log_sel_q <= wd[LW-1:0];
		end
	end

	// axi4-lite read side
	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire [31:0] status_word = {11'h000, code_q, 2'h0, ~write_enable_q,
		online_q, disp_q, fault_q, lamps_q, 1'b0, state_q};
	wire [31:0] log_word = {{(23-LW){1'b0}}, log_cnt_q, 3'h0,
		log_mem[log_sel_q]};
	logic [31:0] rd_word;
	logic rd_hit;
	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			dpfc_pkg::CTRL_OFFSET: rd_word = {29'h0, ctrl_q[2:1], spin_req_q};
			dpfc_pkg::STATUS_OFFSET: rd_word = status_word;
			dpfc_pkg::LOG_SEL_OFFSET: rd_word = {{(32-LW){1'b0}}, log_sel_q};
			dpfc_pkg::LOG_DATA_OFFSET: rd_word = log_word;
			default: begin
				rd_word = 32'h0;
				rd_hit = 1'b0;
			end
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= dpfc_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~ar_hs & ~(s_axi_rvalid & ~s_axi_rready);
			if (ar_hs) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? dpfc_pkg::RESP_OKAY :
					dpfc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// motor flop follows state_d, so it is up with the state; a fault
	// one cycle later may already abort, hence no look further ahead
	spin_start_a: assert property ((state_q == dpfc_pkg::ST_STOPPED) && start
		|=> state_q == dpfc_pkg::ST_SPINUP && spindle_motor_q)
		else $error("spin-up not started");
	stop_retract_a: assert property ((state_q == dpfc_pkg::ST_SPINDOWN)
		|=> heads_retract_q && !spindle_motor_q)
		else $error("heads not retracted on stop");
	drain_hold_a: assert property (drain && writes_pending
		|=> state_q == dpfc_pkg::ST_DRAIN && spindle_motor_q)
		else $error("spin-down before writes finished");
	// a press in the same cycle hands the lamps to the code display
	fault_lamp_a: assert property (fault_detect && !disp_q && !press
		|=> ##1 lamps_q[dpfc_pkg::LAMP_ERROR])
		else $error("error lamp not lit");
	spin_abort_a: assert property ((state_q == dpfc_pkg::ST_SPINUP) &&
		fault_detect |=> state_q == dpfc_pkg::ST_SPINDOWN)
		else $error("spin-up not aborted on fault");
	offline_code_a: assert property (first_press |=> disp_q ##1
		!online_q && !selected_q)
		else $error("not offline after first press");
	log_store_a: assert property (second_press && !fault_detect |=>
		!fault_q && !disp_q && fault_clear_q &&
		log_cnt_q == (($past(log_cnt_q) == (LW+1)'(LOG_DEPTH)) ?
		$past(log_cnt_q) : $past(log_cnt_q) + 1'b1))
		else $error("second press not handled");
	ready_seek_a: assert property (seek_active
		|=> !ready_cond_q)
		else $error("ready during seek");
	wp_idle_a: assert property (!ready_cond && !drain
		|=> !write_enable_q)
		else $error("writes allowed while not ready");
	unit_select_a: assert property (select_addr != unit_code
		|=> !selected_q)
		else $error("selected on wrong unit address");
	ready_stop_a: assert property (stop |=> !ready_cond_q)
		else $error("ready lamp kept on stop");
	spinup_done_c: cover property ((state_q == dpfc_pkg::ST_SPINUP)
		##1 state_q == dpfc_pkg::ST_READY);
	drain_done_c: cover property (drain ##1
		state_q == dpfc_pkg::ST_SPINDOWN);
	two_press_c: cover property (first_press ##[1:50] second_press);
endmodule // dpfc_panel
`default_nettype wire

// File: dpfc_pkg.sv
// Purpose: shared constants for the disk panel fault control block
// Assumes: 200 MHz aclk, 32-bit AXI4-Lite register access
// Notes: lamp vectors are {spindle, error, ready, lockout, port_a, port_b}
package dpfc_pkg;
	// timing
	localparam int CLK_MHZ = 200;
	localparam int BLINK_MS = 250;
	localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] LOG_SEL_OFFSET = 8'h08;
	localparam logic [7:0] LOG_DATA_OFFSET = 8'h0C;
	// control fields
	localparam int CTRL_SPIN_REQ_BIT = 0;
	localparam int CTRL_DISABLE_BIT = 1;
	localparam int CTRL_PORT_B_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	// status fields
	localparam int STATUS_STATE_LSB = 0;
	localparam int STATUS_LAMP_LSB = 4;
	localparam int STATUS_FAULT_BIT = 10;
	localparam int STATUS_DISP_BIT = 11;
	localparam int STATUS_ONLINE_BIT = 12;
	localparam int STATUS_WP_BIT = 13;
	localparam int STATUS_CODE_LSB = 16;
	// log
	localparam int LOG_DEPTH = 16;
	localparam int LOG_DATA_COUNT_LSB = 8;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// lamp vector bit positions
	localparam int LAMP_SPINDLE = 5;
	localparam int LAMP_ERROR = 4;
	localparam int LAMP_READY = 3;
	localparam int LAMP_LOCKOUT = 2;
	localparam int LAMP_PORT_A = 1;
	localparam int LAMP_PORT_B = 0;
	// fault code to lamp pattern, index is the 5-bit fault code
	localparam int FAULT_CODES = 25;
	localparam logic [5:0] FAULT_LAMPS [0:FAULT_CODES-1] = '{
		6'h00, 6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17,
		6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D, 6'h1E, 6'h1F,
		6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36, 6'h2F,
		6'h3F};
	typedef enum logic [2:0] {
		ST_STOPPED, ST_SPINUP, ST_READY, ST_DRAIN, ST_SPINDOWN
	} dpfc_state_type;
endpackage

// File: dpfc_lamp_mux.sv
// Purpose: panel lamp driver, normal lamps or blinking fault code
// Assumes: fault code stable while display is on
// Notes: blink half period is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
module dpfc_lamp_mux #(
	parameter int BLINK_CYCLES = dpfc_pkg::BLINK_CYCLES
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// lamp sources
	input wire logic display_on,
	input wire logic [4:0] fault_code,
	input wire logic [5:0] normal_lamps,
	// lamp pins
	output logic [5:0] lamps_q
);
	logic [31:0] blink_cnt_q;
	logic blink_q;
	wire blink_wrap = blink_cnt_q >= 32'(BLINK_CYCLES - 1);
	wire code_ok = 32'(fault_code) < 32'(dpfc_pkg::FAULT_CODES);
	wire [5:0] code_lamps = code_ok ?
		dpfc_pkg::FAULT_LAMPS[fault_code] : 6'h3F;
	wire [5:0] lamps_d = display_on ?
		(blink_q ? code_lamps : 6'h00) : normal_lamps;
	always_ff @(posedge aclk) begin
		if (!aresetn || !display_on) begin
			blink_cnt_q <= 32'h0;
			blink_q <= 1'b1;
		end else if (blink_wrap) begin
			blink_cnt_q <= 32'h0;
			blink_q <= ~blink_q;
		end else begin
			blink_cnt_q <= blink_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lamps_q <= 6'h00;
		else
			lamps_q <= lamps_d;
	end
endmodule // dpfc_lamp_mux
`default_nettype wire

// File: dpfc_host_model.sv
// Purpose: host controller stand-in on the select lines and write queue
// Assumes: a single drive unit shares the select lines
// Notes: retires one write every RETIRE+1 cycles, every RETIRE*4+1 cycles in slow mode
`timescale 1ns/1ps
`default_nettype none
module dpfc_host_model #(
	parameter int RETIRE = 3
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// bench controls
	input wire logic address_unit,
	input wire logic [3:0] target_unit,
	input wire logic issue_write,
	input wire logic slow,
	// drive side
	output logic [3:0] select_addr,
	output logic writes_pending
);
	logic [3:0] pend_q;
	logic [7:0] tick_q;
	logic [7:0] span;
	// idle lines carry a non-matching address, never the last one
	assign select_addr = address_unit ? target_unit : ~target_unit;
	assign span = slow ? 8'(RETIRE * 4) : 8'(RETIRE);
	assign writes_pending = (pend_q != 4'h0);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend_q <= 4'h0;
			tick_q <= 8'h00;
		end else if (issue_write) begin
			pend_q <= pend_q + 4'h1;
		end else if (pend_q != 4'h0) begin
			tick_q <= (tick_q >= span) ? 8'h00 : tick_q + 8'h01;
			if (tick_q >= span) pend_q <= pend_q - 4'h1;
		end
	end
endmodule // dpfc_host_model
`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the panel fault control block
// Assumes: blink half period cut to 4 cycles, buttons debounced
// Notes: spindle mechanics are played by hand inside each scenario
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic aclk, aresetn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, unit_code, select_addr;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic spindle_button_in, lockout_button_lamp_in, error_button;
	logic port_a_button_in, port_b_button_in, dual_port_fitted;
	logic spindle_rotating, spindle_at_speed, seek_active, writes_pending;
	logic fault_detect, fault_self_corrected;
	logic [4:0] fault_code_in;
	logic spindle_motor_q, heads_retract_q, fault_clear_q, write_enable_q;
	logic online_q, selected_q, port_a_enable_q, port_b_enable_q;
	logic [5:0] lamps_q;
	logic addr_unit, issue_wr, slow;
	logic [31:0] d;
	int mismatches, compares;
	localparam logic [5:0] PAT [1:24] = '{6'h11, 6'h12, 6'h13, 6'h14,
		6'h15, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1A, 6'h1B, 6'h1C, 6'h1D,
		6'h1E, 6'h1F, 6'h30, 6'h31, 6'h32, 6'h33, 6'h34, 6'h35, 6'h36,
		6'h2F, 6'h3F};
	localparam int SP = dpfc_pkg::LAMP_SPINDLE;
	localparam int ER = dpfc_pkg::LAMP_ERROR;
	localparam int RD = dpfc_pkg::LAMP_READY;

	dpfc_panel #(.BLINK_CYCLES(4)) dpfc_panel_inst (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .spindle_button_in, .lockout_button_lamp_in,
		.port_a_button_in, .port_b_button_in, .error_button,
		.spindle_rotating, .spindle_at_speed, .seek_active, .writes_pending,
		.fault_detect, .fault_code_in, .fault_self_corrected, .unit_code,
		.select_addr, .dual_port_fitted, .spindle_motor_q, .heads_retract_q,
		.fault_clear_q, .write_enable_q, .online_q, .selected_q,
		.port_a_enable_q, .port_b_enable_q, .lamps_q);
	dpfc_host_model dpfc_host_model_inst (.aclk, .aresetn,
		.address_unit(addr_unit), .target_unit(unit_code),
		.issue_write(issue_wr), .slow, .select_addr, .writes_pending);

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic conclude;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	// master holds each channel until its own ready edge
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic axr(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask
	task automatic pulse_fault(input logic [4:0] c);
		fault_code_in <= c;
		fault_detect <= 1'b1;
		cyc(1);
		fault_detect <= 1'b0;
		cyc(4);
	endtask

	// button latched at power-up waits for the host request
	task automatic t_powerup;
		cyc(8);
		chk(heads_retract_q, 1'b1);
		chk(spindle_motor_q, 1'b0);
		axr(dpfc_pkg::CTRL_OFFSET);
		chk(d[2:0], dpfc_pkg::CTRL_RESET);
		axw(dpfc_pkg::CTRL_OFFSET, 32'h0000_0001);
		cyc(4);
		chk({spindle_motor_q, heads_retract_q}, 2'h2);
		spindle_rotating <= 1'b1;
		cyc(4);
		chk({lamps_q[SP], lamps_q[RD]}, 2'h2);
		spindle_at_speed <= 1'b1;
		cyc(6);
		chk({lamps_q[RD], write_enable_q}, 2'h3);
	endtask
	task automatic t_ready_ctl;
		lockout_button_lamp_in <= 1'b1;
		seek_active <= 1'b1;
		cyc(5);
		chk({write_enable_q, lamps_q[2], lamps_q[RD]}, 3'h2);
		lockout_button_lamp_in <= 1'b0;
		seek_active <= 1'b0;
		addr_unit <= 1'b0;
		cyc(5);
		chk({write_enable_q, lamps_q[2], lamps_q[RD]}, 3'h5);
		chk(selected_q, 1'b0);
		addr_unit <= 1'b1;
		cyc(4);
		chk(selected_q, 1'b1);
	endtask
	task automatic t_ports;
		for (int i = 0; i < 4; i++) begin
			{port_a_button_in, port_b_button_in} <= 2'(i);
			cyc(5);
			chk({port_a_enable_q, port_b_enable_q, lamps_q[1:0]},
				{2{i[1], i == 1}});
		end
		axw(dpfc_pkg::CTRL_OFFSET, 32'h0000_0004);
		cyc(5);
		chk({port_a_enable_q, port_b_enable_q, lamps_q[1:0]}, 4'h5);
		// disable flag forces the drive off-line and deselected
		axw(dpfc_pkg::CTRL_OFFSET, 32'h0000_0002);
		cyc(3);
		chk({online_q, selected_q}, 2'h0);
		axw(dpfc_pkg::CTRL_OFFSET, 32'h0000_0000);
		cyc(3);
		chk({online_q, selected_q}, 2'h3);
		axw(8'h10, 32'h0000_0001);
		chk(r, dpfc_pkg::RESP_SLVERR);
		axw(dpfc_pkg::STATUS_OFFSET, 32'h0000_0000);
		chk(r, dpfc_pkg::RESP_SLVERR);
		axr(8'h10);
		chk(d, 32'h0);
		chk(r, dpfc_pkg::RESP_SLVERR);
	endtask
	task automatic t_selfcorrect;
		pulse_fault(5'h01);
		chk(lamps_q[ER], 1'b1);
		fault_self_corrected <= 1'b1;
		cyc(1);
		fault_self_corrected <= 1'b0;
		cyc(4);
		chk(lamps_q[ER], 1'b0);
		axr(dpfc_pkg::STATUS_OFFSET);
		// state held in ready, code 1 latched, lamps and flags normal
		chk(d, 32'h0001_12A2);
	endtask
	// fault codes 1 to 24 shown, cleared and logged; log count saturates
	task automatic t_codes;
		logic seen, dark, stray, cl;
		for (int k = 1; k <= 24; k++) begin
			pulse_fault(5'(k));
			{seen, dark, stray, cl} = 4'h0;
			error_button <= 1'b1;
			cyc(1);
			error_button <= 1'b0;
			// code reaches the lamp flops two edges after the press
			cyc(1);
			for (int j = 0; j < 12; j++) begin
				cyc(1);
				seen |= (lamps_q === PAT[k]);
				dark |= (lamps_q === 6'h00);
				stray |= |(lamps_q & ~PAT[k]);
			end
			chk({seen, stray}, 2'h2);
			chk({dark, online_q}, 2'h2);
			error_button <= 1'b1;
			cyc(1);
			error_button <= 1'b0;
			for (int j = 0; j < 6; j++) begin
				cyc(1);
				cl |= (fault_clear_q === 1'b1);
			end
			cyc(4);
			chk({cl, lamps_q[ER], online_q}, 3'h5);
		end
		axr(dpfc_pkg::LOG_DATA_OFFSET);
		chk(d[12:8], 5'h10);
		// slot 0 wrapped: code 1 overwritten by code 17
		chk(d[4:0], 5'h11);
	endtask
	task automatic t_stop;
		slow <= 1'b1;
		issue_wr <= 1'b1;
		cyc(2);
		issue_wr <= 1'b0;
		spindle_button_in <= 1'b0;
		cyc(4);
		chk({lamps_q[RD], spindle_motor_q}, 2'h1);
		cyc(60);
		chk({spindle_motor_q, heads_retract_q}, 2'h1);
		chk(lamps_q[SP], 1'b1);
		spindle_rotating <= 1'b0;
		spindle_at_speed <= 1'b0;
		cyc(4);
		chk({lamps_q[SP], write_enable_q}, 2'h0);
	endtask
	task automatic t_abort;
		// restart gap compressed; a real operator waits minutes here
		spindle_button_in <= 1'b1;
		cyc(4);
		chk(spindle_motor_q, 1'b1);
		spindle_rotating <= 1'b1;
		pulse_fault(5'h02);
		chk(spindle_motor_q, 1'b0);
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready, error_button} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{lockout_button_lamp_in, port_a_button_in, port_b_button_in} = '0;
		{spindle_rotating, spindle_at_speed, seek_active} = 3'h0;
		{fault_detect, fault_self_corrected, fault_code_in} = '0;
		{issue_wr, slow} = 2'h0;
		s_axi_wstrb = 4'hF;
		unit_code = 4'h9;
		addr_unit = 1'b1;
		dual_port_fitted = 1'b1;
		spindle_button_in = 1'b1;
		aresetn = 1'b0;
		cyc(10);
		aresetn <= 1'b1;
		t_powerup();
		t_ready_ctl();
		t_ports();
		t_selfcorrect();
		t_codes();
		t_stop();
		t_abort();
		conclude();
	end
	initial begin
		cyc(20000);
		mismatches++;
		conclude();
	end
endmodule // tb_top
`default_nettype wire
